// ---- hw/drive_pkg.sv ----
// constants and types for the drive state and mode block
package drive_pkg;

  // object indices
  localparam logic [15:0] IDX_CTL_WORD  = 16'h6040;
  localparam logic [15:0] IDX_STATUS    = 16'h6041;
  localparam logic [15:0] IDX_SLOW_STOP = 16'h6050;
  localparam logic [15:0] IDX_FAST_STOP = 16'h6051;
  localparam logic [15:0] IDX_QS_OPT    = 16'h605A;
  localparam logic [15:0] IDX_FR_OPT    = 16'h605E;
  localparam logic [15:0] IDX_MODE_SEL  = 16'h6060;
  localparam logic [15:0] IDX_MODE_DISP = 16'h6061;

  // reset values
  localparam logic [15:0] RST_CTL_WORD  = 16'h0000;
  localparam logic [31:0] RST_STOP_TIME = 32'h0000_0000;
  localparam logic [15:0] RST_OPTION    = 16'h0000;
  localparam logic [7:0]  RST_MODE      = 8'h07;

  // status word bit positions
  localparam int SW_RDY_ON   = 0;
  localparam int SW_ON       = 1;
  localparam int SW_OP_EN    = 2;
  localparam int SW_FAULT    = 3;
  localparam int SW_VOLT     = 4;
  localparam int SW_QSTOP    = 5;
  localparam int SW_ON_DIS   = 6;
  localparam int SW_WARN     = 7;
  localparam int SW_TARGET   = 10;
  localparam int SW_MODE_A   = 12;
  localparam int SW_MODE_B   = 13;

  // control word bit positions
  localparam int CW_SWITCH   = 0;
  localparam int CW_VOLT     = 1;
  localparam int CW_QSTOP_N  = 2;
  localparam int CW_ENABLE   = 3;
  localparam int CW_FLT_RST  = 7;

  // operating mode codes
  localparam logic [7:0] MODE_PROF_POS = 8'h01;
  localparam logic [7:0] MODE_PROF_VEL = 8'h03;
  localparam logic [7:0] MODE_PROF_TRQ = 8'h04;
  localparam logic [7:0] MODE_HOMING   = 8'h06;
  localparam logic [7:0] MODE_INTERP   = 8'h07;

  // stop option codes
  localparam logic [15:0] QS_COAST     = 16'h0000;
  localparam logic [15:0] QS_FAST_DIS  = 16'h0001;
  localparam logic [15:0] QS_SLOW_DIS  = 16'h0002;
  localparam logic [15:0] QS_FAST_HOLD = 16'h0003;
  localparam logic [15:0] QS_SLOW_HOLD = 16'h0004;
  localparam logic [15:0] FR_FAST      = 16'h0001;
  localparam logic [15:0] FR_SLOW      = 16'h0002;

  // timing
  localparam int unsigned STOP_UNIT_MS  = 1;
  localparam int unsigned MS_IN_PS      = 1000000000;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned MS_CYCLES     =
    (STOP_UNIT_MS * MS_IN_PS) / CLK_PERIOD_PS;

  // divider length
  localparam logic [5:0] DIV_LAST = 6'h1F;

  // number of synchronised condition inputs
  localparam int SYNC_W = 9;

  typedef enum logic [2:0] {
    ST_NOT_READY,
    ST_ON_DISABLED,
    ST_READY,
    ST_SWITCHED_ON,
    ST_OP_ENABLED,
    ST_QSTOP,
    ST_FAULT_REACT,
    ST_FAULT
  } drive_state_t;

  typedef enum logic [1:0] {
    RG_IDLE,
    RG_DIV,
    RG_RUN,
    RG_HELD
  } ramp_state_t;

endpackage

// ---- hw/stop_ramp_gen.sv ----
// linear stop ramp generator with millisecond timebase
`timescale 1ns/10ps
module stop_ramp_gen
  import drive_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = MS_CYCLES
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  // control
  input  wire logic               start,
  input  wire logic               stop_active,
  input  wire logic        [31:0] stop_time_ms,
  // speed path
  input  wire logic signed [31:0] speed_in,
  output logic signed      [31:0] speed_out,
  output logic                    busy
);

  ramp_state_t        rstate,   next_rstate;
  logic        [31:0] mag,      next_mag;
  logic               neg,      next_neg;
  logic        [31:0] tms,      next_tms;
  logic        [31:0] dvd,      next_dvd;
  logic        [31:0] quo,      next_quo;
  logic        [32:0] rem,      next_rem;
  logic        [5:0]  bitc,     next_bitc;
  logic        [31:0] tick_cnt, next_tick_cnt;
  logic        [31:0] ms_cnt,   next_ms_cnt;
  logic        [32:0] racc,     next_racc;
  logic signed [31:0] next_speed_out;
  logic               next_busy;

  always_comb begin
    logic [32:0] trial;
    logic [32:0] sum;
    logic        carry;
    logic [31:0] in_mag;
    trial = {rem[31:0], dvd[31]};
    sum = racc + rem;
    carry = (sum >= {1'b0, tms});
    in_mag = speed_in[31] ? 32'(-speed_in) : 32'(speed_in);
    next_rstate = rstate;
    next_mag = mag;
    next_neg = neg;
    next_tms = tms;
    next_dvd = dvd;
    next_quo = quo;
    next_rem = rem;
    next_bitc = bitc;
    next_tick_cnt = tick_cnt;
    next_ms_cnt = ms_cnt;
    next_racc = racc;
    unique case (rstate)
      RG_IDLE: begin
        next_mag = in_mag;
        next_neg = speed_in[31];
        if (start) begin
          next_tms = stop_time_ms;
          next_dvd = in_mag;
          next_quo = 32'h0000_0000;
          next_rem = 33'h0_0000_0000;
          next_bitc = 6'h00;
          if (stop_time_ms == RST_STOP_TIME) begin
            next_mag = 32'h0000_0000;
            next_rstate = RG_HELD;
          end else begin
            next_rstate = RG_DIV;
          end
        end
      end
      RG_DIV: begin
        // per-ms step and remainder of the linear descent
        next_rem = (trial >= {1'b0, tms}) ? 33'(trial - tms) : trial;
        next_quo = {quo[30:0], trial >= {1'b0, tms}};
        next_dvd = {dvd[30:0], 1'b0};
        next_bitc = 6'(bitc + 6'h01);
        if (bitc == DIV_LAST) begin
          next_tick_cnt = 32'h0000_0000;
          next_ms_cnt = 32'h0000_0000;
          next_racc = 33'h0_0000_0000;
          next_rstate = RG_RUN;
        end
      end
      RG_RUN: begin
        if (tick_cnt == 32'(CYCLES_PER_MS - 1)) begin
          next_tick_cnt = 32'h0000_0000;
          next_racc = carry ? 33'(sum - tms) : sum;
          next_mag = 32'(mag - quo - {31'h0000_0000, carry});
          next_ms_cnt = 32'(ms_cnt + 32'h0000_0001);
          if (ms_cnt == 32'(tms - 32'h0000_0001)) begin
            next_mag = 32'h0000_0000;
            next_rstate = RG_HELD;
          end
        end else begin
          next_tick_cnt = 32'(tick_cnt + 32'h0000_0001);
        end
      end
      RG_HELD: begin
        next_mag = 32'h0000_0000;
        if (!stop_active) begin
          next_rstate = RG_IDLE;
        end
      end
    endcase
    if ((rstate == RG_DIV || rstate == RG_RUN) && !stop_active) begin
      next_rstate = RG_IDLE;
    end
    next_speed_out = next_neg ? -$signed(next_mag) : $signed(next_mag);
    next_busy = (next_rstate == RG_DIV) || (next_rstate == RG_RUN);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rstate <= RG_IDLE;
      mag <= 32'h0000_0000;
      neg <= 1'b0;
      tms <= 32'h0000_0000;
      dvd <= 32'h0000_0000;
      quo <= 32'h0000_0000;
      rem <= 33'h0_0000_0000;
      bitc <= 6'h00;
      tick_cnt <= 32'h0000_0000;
      ms_cnt <= 32'h0000_0000;
      racc <= 33'h0_0000_0000;
      speed_out <= 32'sh0000_0000;
      busy <= 1'b0;
    end else begin
      rstate <= next_rstate;
      mag <= next_mag;
      neg <= next_neg;
      tms <= next_tms;
      dvd <= next_dvd;
      quo <= next_quo;
      rem <= next_rem;
      bitc <= next_bitc;
      tick_cnt <= next_tick_cnt;
      ms_cnt <= next_ms_cnt;
      racc <= next_racc;
      speed_out <= next_speed_out;
      busy <= next_busy;
    end
  end

endmodule

// ---- hw/drive_state_status_mode_select.sv ----
// drive state machine, status word, stop options and mode selection
`timescale 1ns/10ps
module drive_state_status_mode_select
  import drive_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = MS_CYCLES
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  // object access
  input  wire logic        [15:0] obj_index,
  input  wire logic               obj_wr,
  input  wire logic               obj_rd,
  input  wire logic        [31:0] obj_wdata,
  output logic             [31:0] obj_rdata,
  output logic                    obj_ack,
  output logic                    obj_err,
  // drive condition pins
  input  wire logic               fault_det,
  input  wire logic               warning_det,
  input  wire logic               voltage_ok,
  input  wire logic               target_reached,
  input  wire logic               setpoint_ack,
  input  wire logic               homing_done,
  input  wire logic               homing_err,
  input  wire logic               follow_err,
  input  wire logic               interp_active,
  // speed path
  input  wire logic signed [31:0] speed_cmd_in,
  output logic signed      [31:0] speed_cmd_out,
  output logic                    torque_enable,
  // state view
  output logic             [15:0] drive_status_word,
  output logic             [7:0]  operating_mode_display
);

  // pin synchronisers
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;

  assign sync_raw = {interp_active, follow_err, homing_err, homing_done,
                     setpoint_ack, target_reached, voltage_ok, warning_det,
                     fault_det};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= sync_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  logic fault_s, warn_s, volt_s, target_s, ack_s;
  logic homed_s, home_err_s, follow_s, interp_s;
  assign {interp_s, follow_s, home_err_s, homed_s, ack_s, target_s,
          volt_s, warn_s, fault_s} = sync_b;

  // object registers
  logic        [15:0] ctl_word,              next_ctl_word;
  logic        [31:0] slow_stop_time,        next_slow_stop_time;
  logic        [31:0] fast_stop_time,        next_fast_stop_time;
  logic        [15:0] quick_stop_option,     next_quick_stop_option;
  logic        [15:0] fault_reaction_option, next_fault_reaction_option;
  logic        [7:0]  operating_mode_select, next_operating_mode_select;
  logic        [7:0]  next_mode_display;
  logic        [31:0] next_obj_rdata;
  logic               next_obj_ack;
  logic               next_obj_err;
  logic               flt_rst_edge,          next_flt_rst_edge;

  function automatic logic mode_ok(input logic [7:0] m);
    mode_ok = (m == MODE_PROF_POS) || (m == MODE_PROF_VEL) ||
              (m == MODE_PROF_TRQ) || (m == MODE_HOMING) ||
              (m == MODE_INTERP);
  endfunction

  always_comb begin
    next_ctl_word = ctl_word;
    next_slow_stop_time = slow_stop_time;
    next_fast_stop_time = fast_stop_time;
    next_quick_stop_option = quick_stop_option;
    next_fault_reaction_option = fault_reaction_option;
    next_operating_mode_select = operating_mode_select;
    next_mode_display = operating_mode_display;
    next_obj_rdata = obj_rdata;
    next_obj_ack = obj_wr || obj_rd;
    next_obj_err = 1'b0;
    next_flt_rst_edge = 1'b0;
    if (obj_wr) begin
      unique case (obj_index)
        IDX_CTL_WORD: begin
          next_ctl_word = obj_wdata[15:0];
          next_flt_rst_edge = obj_wdata[CW_FLT_RST] && !ctl_word[CW_FLT_RST];
        end
        IDX_SLOW_STOP: next_slow_stop_time = obj_wdata;
        IDX_FAST_STOP: next_fast_stop_time = obj_wdata;
        IDX_QS_OPT:    next_quick_stop_option = obj_wdata[15:0];
        IDX_FR_OPT:    next_fault_reaction_option = obj_wdata[15:0];
        IDX_MODE_SEL: begin
          next_operating_mode_select = obj_wdata[7:0];
          if (mode_ok(obj_wdata[7:0])) begin
            next_mode_display = obj_wdata[7:0];
          end
        end
        default: next_obj_err = 1'b1;
      endcase
    end else if (obj_rd) begin
      unique case (obj_index)
        IDX_CTL_WORD:  next_obj_rdata = {16'h0000, ctl_word};
        IDX_STATUS:    next_obj_rdata = {16'h0000, drive_status_word};
        IDX_SLOW_STOP: next_obj_rdata = slow_stop_time;
        IDX_FAST_STOP: next_obj_rdata = fast_stop_time;
        IDX_QS_OPT:    next_obj_rdata = {16'h0000, quick_stop_option};
        IDX_FR_OPT:    next_obj_rdata = {16'h0000, fault_reaction_option};
        IDX_MODE_SEL:  next_obj_rdata = {24'h00_0000, operating_mode_select};
        IDX_MODE_DISP: next_obj_rdata = {24'h00_0000, operating_mode_display};
        default: begin
          next_obj_rdata = 32'h0000_0000;
          next_obj_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_word <= RST_CTL_WORD;
      slow_stop_time <= RST_STOP_TIME;
      fast_stop_time <= RST_STOP_TIME;
      quick_stop_option <= RST_OPTION;
      fault_reaction_option <= RST_OPTION;
      operating_mode_select <= RST_MODE;
      operating_mode_display <= RST_MODE;
      obj_rdata <= 32'h0000_0000;
      obj_ack <= 1'b0;
      obj_err <= 1'b0;
      flt_rst_edge <= 1'b0;
    end else begin
      ctl_word <= next_ctl_word;
      slow_stop_time <= next_slow_stop_time;
      fast_stop_time <= next_fast_stop_time;
      quick_stop_option <= next_quick_stop_option;
      fault_reaction_option <= next_fault_reaction_option;
      operating_mode_select <= next_operating_mode_select;
      operating_mode_display <= next_mode_display;
      obj_rdata <= next_obj_rdata;
      obj_ack <= next_obj_ack;
      obj_err <= next_obj_err;
      flt_rst_edge <= next_flt_rst_edge;
    end
  end

  // control word decode
  logic cmd_shutdown, cmd_switch_on, cmd_enable, cmd_dis_volt, cmd_qstop;
  assign cmd_shutdown  = ctl_word[CW_QSTOP_N] && ctl_word[CW_VOLT] &&
                         !ctl_word[CW_SWITCH];
  assign cmd_switch_on = ctl_word[CW_QSTOP_N] && ctl_word[CW_VOLT] &&
                         ctl_word[CW_SWITCH] && !ctl_word[CW_ENABLE];
  assign cmd_enable    = ctl_word[CW_QSTOP_N] && ctl_word[CW_VOLT] &&
                         ctl_word[CW_SWITCH] && ctl_word[CW_ENABLE];
  assign cmd_dis_volt  = !ctl_word[CW_VOLT];
  assign cmd_qstop     = ctl_word[CW_VOLT] && !ctl_word[CW_QSTOP_N];

  // drive state machine
  drive_state_t       state,      next_state;
  logic               stop_coast, next_stop_coast;
  logic               stop_hold,  next_stop_hold;
  logic               ramp_start, next_ramp_start;
  logic        [31:0] ramp_time,  next_ramp_time;
  logic               stop_act,   next_stop_act;
  logic               next_torque;
  logic signed [31:0] next_speed;
  logic        [15:0] next_status;
  logic signed [31:0] ramp_speed;
  logic               ramp_busy;
  logic               stop_done;

  assign stop_done = !ramp_busy && !ramp_start;

  always_comb begin
    next_state = state;
    next_stop_coast = stop_coast;
    next_stop_hold = stop_hold;
    next_ramp_start = 1'b0;
    next_ramp_time = ramp_time;
    if (fault_s && state != ST_FAULT_REACT && state != ST_FAULT) begin
      next_state = ST_FAULT_REACT;
      next_stop_hold = 1'b0;
      if (torque_enable && (fault_reaction_option == FR_FAST ||
                            fault_reaction_option == FR_SLOW)) begin
        next_stop_coast = 1'b0;
        next_ramp_start = 1'b1;
        next_ramp_time = (fault_reaction_option == FR_FAST) ?
                         fast_stop_time : slow_stop_time;
      end else begin
        next_stop_coast = 1'b1;
      end
    end else begin
      unique case (state)
        ST_NOT_READY: next_state = ST_ON_DISABLED;
        ST_ON_DISABLED: begin
          if (cmd_shutdown) next_state = ST_READY;
        end
        ST_READY: begin
          if (cmd_dis_volt || cmd_qstop) next_state = ST_ON_DISABLED;
          else if (cmd_switch_on || cmd_enable) next_state = ST_SWITCHED_ON;
        end
        ST_SWITCHED_ON: begin
          if (cmd_dis_volt || cmd_qstop) next_state = ST_ON_DISABLED;
          else if (cmd_shutdown) next_state = ST_READY;
          else if (cmd_enable) next_state = ST_OP_ENABLED;
        end
        ST_OP_ENABLED: begin
          if (cmd_dis_volt) next_state = ST_ON_DISABLED;
          else if (cmd_shutdown) next_state = ST_READY;
          else if (cmd_switch_on) next_state = ST_SWITCHED_ON;
          else if (cmd_qstop) begin
            next_state = ST_QSTOP;
            next_stop_hold = (quick_stop_option == QS_FAST_HOLD) ||
                             (quick_stop_option == QS_SLOW_HOLD);
            next_stop_coast = !((quick_stop_option == QS_FAST_DIS) ||
                                (quick_stop_option == QS_SLOW_DIS) ||
                                next_stop_hold);
            next_ramp_start = !next_stop_coast;
            next_ramp_time = ((quick_stop_option == QS_FAST_DIS) ||
                              (quick_stop_option == QS_FAST_HOLD)) ?
                             fast_stop_time : slow_stop_time;
          end
        end
        ST_QSTOP: begin
          if (cmd_dis_volt) next_state = ST_ON_DISABLED;
          else if (!stop_hold && stop_done) next_state = ST_ON_DISABLED;
          else if (stop_hold && stop_done && cmd_enable)
            next_state = ST_OP_ENABLED;
        end
        ST_FAULT_REACT: begin
          if (stop_done) next_state = ST_FAULT;
        end
        ST_FAULT: begin
          if (flt_rst_edge) next_state = ST_ON_DISABLED;
        end
      endcase
    end
    next_stop_act = (next_state == ST_QSTOP) ||
                    (next_state == ST_FAULT_REACT);
    unique case (next_state)
      ST_OP_ENABLED: next_torque = 1'b1;
      ST_QSTOP, ST_FAULT_REACT: next_torque = !next_stop_coast;
      default: next_torque = 1'b0;
    endcase
    next_speed = next_torque ? ramp_speed : 32'sh0000_0000;
    unique case (next_state)
      ST_NOT_READY:   next_status = 16'h0000;
      ST_ON_DISABLED: next_status = 16'h0040;
      ST_READY:       next_status = 16'h0021;
      ST_SWITCHED_ON: next_status = 16'h0023;
      ST_OP_ENABLED:  next_status = 16'h0027;
      ST_QSTOP:       next_status = 16'h0007;
      ST_FAULT_REACT: next_status = 16'h000F;
      ST_FAULT:       next_status = 16'h0008;
    endcase
    next_status[SW_VOLT] = volt_s;
    next_status[SW_WARN] = warn_s;
    next_status[SW_TARGET] = target_s;
    unique case (operating_mode_display)
      MODE_PROF_POS: begin
        next_status[SW_MODE_A] = ack_s;
        next_status[SW_MODE_B] = follow_s;
      end
      MODE_HOMING: begin
        next_status[SW_MODE_A] = homed_s;
        next_status[SW_MODE_B] = home_err_s;
      end
      MODE_INTERP: next_status[SW_MODE_A] = interp_s;
      MODE_PROF_VEL: next_status[SW_MODE_A] = (ramp_speed == 0);
      default: next_status[SW_MODE_A] = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_NOT_READY;
      stop_coast <= 1'b0;
      stop_hold <= 1'b0;
      ramp_start <= 1'b0;
      ramp_time <= RST_STOP_TIME;
      stop_act <= 1'b0;
      torque_enable <= 1'b0;
      speed_cmd_out <= 32'sh0000_0000;
      drive_status_word <= 16'h0000;
    end else begin
      state <= next_state;
      stop_coast <= next_stop_coast;
      stop_hold <= next_stop_hold;
      ramp_start <= next_ramp_start;
      ramp_time <= next_ramp_time;
      stop_act <= next_stop_act;
      torque_enable <= next_torque;
      speed_cmd_out <= next_speed;
      drive_status_word <= next_status;
    end
  end

  stop_ramp_gen #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_ramp (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .start        (ramp_start),
    .stop_active  (stop_act),
    .stop_time_ms (ramp_time),
    .speed_in     (speed_cmd_in),
    .speed_out    (ramp_speed),
    .busy         (ramp_busy)
  );

endmodule

// ---- sim/drive_chk.sv ----
// port checker for the drive block
`timescale 1ns/10ps
module drive_chk
  import drive_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               sys_rst,
  input wire logic        [15:0] obj_index,
  input wire logic               obj_wr,
  input wire logic        [31:0] obj_wdata,
  input wire logic               obj_ack,
  input wire logic               torque_enable,
  input wire logic signed [31:0] speed_cmd_out,
  input wire logic        [15:0] drive_status_word,
  input wire logic        [7:0]  operating_mode_display
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire [7:0] wm = obj_wdata[7:0];
  wire       ok_md = wm inside {8'h01, 8'h03, 8'h04, 8'h06, 8'h07};
  wire [3:0] lo = drive_status_word[3:0];
  wire [1:0] qd = drive_status_word[6:5];
  sequence msel;
    obj_wr && obj_index == IDX_MODE_SEL;
  endsequence
  sequence flt2;
    (lo == 4'h8) [*2];
  endsequence
  AST_ACK: assert property (obj_wr |=> obj_ack)
    else $error("write not acknowledged");
  AST_MODE: assert property (msel ##0 ok_md |=>
    operating_mode_display == $past(wm))
    else $error("mode not applied");
  AST_RSVD: assert property (msel ##0 !ok_md |=>
    $stable(operating_mode_display))
    else $error("reserved mode applied");
  AST_EN: assert property (qd == 2'b01 && lo == 4'h7 |-> torque_enable)
    else $error("enabled without torque");
  AST_RDY: assert property (qd == 2'b01 && lo[2] == 1'b0 |->
    !torque_enable)
    else $error("torque before enable");
  AST_DIS: assert property (drive_status_word[6] |->
    lo == 4'h0 && !torque_enable)
    else $error("disabled state not clean");
  AST_FLT: assert property (flt2 |->
    !torque_enable && speed_cmd_out == 0)
    else $error("fault state still driving");
  AST_COAST: assert property ((!torque_enable) [*2] |->
    speed_cmd_out == 0)
    else $error("speed without torque");
endmodule
bind drive_state_status_mode_select drive_chk chk (.*);

// ---- sim/net_master.sv ----
// fieldbus master model issuing object accesses
`timescale 1ns/10ps
module net_master (
  input  wire logic        ref_clk,
  input  wire logic        obj_ack,
  input  wire logic        obj_err,
  input  wire logic [31:0] obj_rdata,
  output logic      [15:0] obj_index = 16'h0000,
  output logic             obj_wr = 1'b0,
  output logic             obj_rd = 1'b0,
  output logic      [31:0] obj_wdata = 32'h0
);
  task automatic acc(input logic w, input logic [15:0] i,
    input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    #1;
    {obj_index, obj_wdata, obj_wr, obj_rd} = {i, d, w, !w};
    @(posedge ref_clk);
    #1;
    {obj_wr, obj_rd} = 2'b00;
    for (n = 0; n < 4 && obj_ack !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    r = {obj_ack, obj_err};
    q = obj_rdata;
    @(posedge ref_clk);
    #1;
    obj_wdata = ~d;
  endtask
endmodule

// ---- sim/drive_state_status_mode_select_test.sv ----
// self-checking bench for the drive state and mode block
`timescale 1ns/10ps
module drive_state_status_mode_select_test;
  import drive_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [8:0] pin = 9'h000;
  logic signed [31:0] spd = 32'sh0;
  logic signed [31:0] so;
  logic [15:0] idx, sw;
  logic [31:0] wd, rdat, q;
  logic [7:0] disp;
  logic [1:0] r;
  logic wr, rd, ack, err, ten;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 45808;
  int mode = 7;
  int codes[$] = '{1, 6, 0, 3, 4, 5, 7, 128};
  always #12.5 ref_clk = ~ref_clk;
  net_master m (.ref_clk(ref_clk), .obj_ack(ack), .obj_err(err),
    .obj_rdata(rdat), .obj_index(idx), .obj_wr(wr), .obj_rd(rd),
    .obj_wdata(wd));
  drive_state_status_mode_select #(.CYCLES_PER_MS(4)) DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .obj_index(idx), .obj_wr(wr),
    .obj_rd(rd), .obj_wdata(wd), .obj_rdata(rdat), .obj_ack(ack),
    .obj_err(err), .fault_det(pin[0]), .warning_det(pin[1]),
    .voltage_ok(pin[2]), .target_reached(pin[3]), .setpoint_ack(pin[4]),
    .homing_done(pin[5]), .homing_err(pin[6]), .follow_err(pin[7]),
    .interp_active(pin[8]), .speed_cmd_in(spd), .speed_cmd_out(so),
    .torque_enable(ten), .drive_status_word(sw),
    .operating_mode_display(disp));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // write expects the error flag in e, read expects the data
  task automatic acc(input logic w, input logic [15:0] i,
    input logic [31:0] d, input logic [31:0] e);
    m.acc(w, i, d, q, r);
    if (r[1] !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    chk(w ? {31'h0, r[0]} : q, e);
  endtask
  task automatic wait_sw(input logic [15:0] k, input logic [15:0] e);
    int n;
    for (n = 0; n < 300 && (sw & k) !== e; n++) @(negedge ref_clk);
    chk({16'h0000, sw & k}, {16'h0000, e});
    if ((sw & k) !== e) wrap_up();
  endtask
  function automatic logic [15:0] hib(int md);
    hib = {5'h00, pin[3], 2'b00, pin[1], 2'b00, pin[2], 4'h0};
    if (md == 7) hib[12] = pin[8];
    if (md == 6) hib[13:12] = pin[6:5];
    if (md == 1) hib[13:12] = {pin[7], pin[4]};
    if (md == 3) hib[12] = (spd == 0);
  endfunction
  task automatic enable();
    acc(1, IDX_CTL_WORD, 6, 0);
    wait_sw(16'h006F, 16'h0021);
    acc(1, IDX_CTL_WORD, 7, 0);
    wait_sw(16'h006F, 16'h0023);
    acc(1, IDX_CTL_WORD, 15, 0);
    wait_sw(16'h006F, 16'h0027);
    chk(so, spd);
  endtask
  initial begin
    pin[8:1] = 8'($random(seed));
    spd = 32'($random(seed) % 20000);
    repeat (4) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    acc(0, IDX_SLOW_STOP, 0, 0);
    acc(0, IDX_FAST_STOP, 0, 0);
    acc(0, IDX_QS_OPT, 0, 0);
    acc(0, IDX_FR_OPT, 0, 0);
    acc(0, IDX_MODE_SEL, 0, 7);
    acc(0, IDX_MODE_DISP, 0, 7);
    wait_sw(16'h006F, 16'h0040);
    acc(1, IDX_SLOW_STOP, 32'hFFFF_FFFF, 0);
    acc(0, IDX_SLOW_STOP, 0, 32'hFFFF_FFFF);
    acc(1, IDX_STATUS, 1, 1);
    acc(1, IDX_MODE_DISP, 1, 1);
    acc(1, 16'h6000, 1, 1);
    acc(1, IDX_SLOW_STOP, 2, 0);
    acc(1, IDX_FAST_STOP, 1, 0);
    acc(0, IDX_FAST_STOP, 0, 1);
    $display("object test done");
    codes.push_back($random(seed) & 255);
    foreach (codes[k]) begin
      acc(1, IDX_MODE_SEL, codes[k], 0);
      if (codes[k] inside {1, 3, 4, 6, 7}) mode = codes[k];
      acc(0, IDX_MODE_SEL, 0, codes[k]);
      acc(0, IDX_MODE_DISP, 0, mode);
      chk({24'h00_0000, disp}, mode);
      wait_sw(16'h3490, hib(mode));
    end
    $display("mode test done");
    for (int o = 0; o < 5; o++) begin
      acc(1, IDX_QS_OPT, o, 0);
      enable();
      acc(1, IDX_CTL_WORD, 2, 0);
      if (o > 0) wait_sw(16'h006F, 16'h0007);
      if (o > 2) begin
        if (o == 4) begin
          repeat (40) @(negedge ref_clk);
          chk(so, spd - spd / 2);
        end
        repeat (80) @(negedge ref_clk);
        wait_sw(16'h006F, 16'h0007);
        chk(so, 0);
        chk(ten, 1);
        acc(1, IDX_CTL_WORD, 15, 0);
        wait_sw(16'h006F, 16'h0027);
        acc(1, IDX_CTL_WORD, 7, 0);
        wait_sw(16'h006F, 16'h0023);
      end else begin
        wait_sw(16'h006F, 16'h0040);
        chk(so, 0);
        chk(ten, 0);
      end
    end
    $display("stop test done");
    for (int f = 2; f >= 0; f--) begin
      enable();
      acc(1, IDX_FR_OPT, f, 0);
      pin[0] = 1'b1;
      if (f > 0) wait_sw(16'h004F, 16'h000F);
      wait_sw(16'h004F, 16'h0008);
      chk(ten, 0);
      chk(so, 0);
      pin[0] = 1'b0;
      acc(1, IDX_CTL_WORD, 16'h0080, 0);
      wait_sw(16'h006F, 16'h0040);
    end
    $display("fault test done");
    wrap_up();
  end
endmodule
